// ---- core/vcc_pkg.sv ----
// package: register map, field layout and state types of the comparator control block
package vcc_pkg;

    localparam logic [31:0] CTRL_ADDR   = 32'hffff0444;
    localparam logic [31:0] MASK_ADDR   = 32'hffff0448;
    localparam logic [15:0] CTRL_RESET  = 16'h0000;
    localparam logic [1:0]  MASK_RESET  = 2'h0;
    localparam int          CTRL_W      = 11;
    localparam int          RISE_BIT    = 1;
    localparam int          FALL_BIT    = 0;
    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

    // negative input codes
    localparam logic [1:0]  SEL_HALF_SUPPLY = 2'h0;
    localparam logic [1:0]  SEL_THIRD_ADC   = 2'h1;
    localparam logic [1:0]  SEL_FIRST_DAC   = 2'h2;

    // result route codes
    localparam logic [1:0]  ROUTE_PIN = 2'h2;
    localparam logic [1:0]  ROUTE_IRQ = 2'h3;

    localparam int          SYNC_STAGES = 3;

    // bits 10:0 of comparator_control, msb first
    typedef struct packed {
        logic       compare_on;
        logic [1:0] minus_input_select;
        logic [1:0] output_route;
        logic       output_polarity;
        logic [1:0] response_speed;
        logic       hysteresis_on;
        logic       rise_flag;
        logic       fall_flag;
    } vcc_ctrl_t;

    typedef struct packed {
        vcc_ctrl_t   ctrl;
        logic [1:0]  mask;
        logic        mon_prev;
        logic        dp_write;
        logic        dp_ctrl;
        logic        dp_mask;
        logic        result_pin;
        logic        pla_out;
        logic        adc_start;
        logic        irq;
        logic        hreadyout;
        logic [31:0] hrdata;
    } vcc_state_t;

    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } vcc_sync_state_t;

endpackage

// ---- core/vcc_sync.sv ----
// three-stage synchroniser with agreement filter for the comparator result
`timescale 1ns/1ps
`default_nettype none
module vcc_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic async_in,
    output logic      level
);
    vcc_pkg::vcc_sync_state_t r;
    vcc_pkg::vcc_sync_state_t next_r;

    always_comb begin
        next_r       = r;
        next_r.stage = {r.stage[1:0], async_in};
        // stage[0] feeds only stage[1]; change accepted when stages 2 and 3 agree
        if (r.stage[1] == r.stage[2]) begin
            next_r.level = r.stage[2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.level;
endmodule
`default_nettype wire

// ---- core/vcc_top.sv ----
// top: ahb-lite slave, control register, edge flags and routing around the comparator
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module vcc_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        comparator_raw,
    output logic             compare_on,
    output logic [1:0]       minus_input_select,
    output logic [1:0]       response_speed,
    output logic             hysteresis_on,
    output logic             result_pin,
    output logic             pla_out,
    output logic             adc_start,
    output logic             irq
);
    localparam vcc_pkg::vcc_state_t RESET_STATE = '{
        ctrl:      vcc_pkg::CTRL_RESET[vcc_pkg::CTRL_W-1:0],
        mask:      vcc_pkg::MASK_RESET,
        hreadyout: 1'b1,
        default:   '0
    };

    vcc_pkg::vcc_state_t r;
    vcc_pkg::vcc_state_t next_r;
    logic                raw_level;
    logic                mon;
    logic                rise_evt;
    logic                fall_evt;
    logic                addr_take;
    logic                wr_ctrl;
    logic                wr_mask;
    logic [1:0]          clr;

    vcc_sync u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (comparator_raw),
        .level    (raw_level)
    );

    always_comb begin
        next_r    = r;
        mon       = raw_level ^ r.ctrl.output_polarity;
        rise_evt  = r.ctrl.compare_on && mon && !r.mon_prev;
        fall_evt  = r.ctrl.compare_on && !mon && r.mon_prev;
        addr_take = hsel && hready && (htrans == vcc_pkg::HTRANS_NSEQ);
        wr_ctrl   = r.dp_write && r.dp_ctrl;
        wr_mask   = r.dp_write && r.dp_mask;
        clr       = wr_ctrl ? hwdata[1:0] : 2'h0;

        // data phase: settings stored, flags write-one-to-clear
        if (wr_ctrl) begin
            next_r.ctrl = vcc_pkg::vcc_ctrl_t'(hwdata[vcc_pkg::CTRL_W-1:0]);
        end
        if (wr_mask) begin
            next_r.mask = hwdata[1:0];
        end
        // set wins over a clear in the same cycle
        next_r.ctrl.rise_flag = (r.ctrl.rise_flag & ~clr[vcc_pkg::RISE_BIT])
                                | rise_evt;
        next_r.ctrl.fall_flag = (r.ctrl.fall_flag & ~clr[vcc_pkg::FALL_BIT])
                                | fall_evt;
        next_r.mon_prev = mon;

        // address phase
        next_r.dp_write = addr_take && hwrite;
        next_r.dp_ctrl  = addr_take && (haddr == vcc_pkg::CTRL_ADDR);
        next_r.dp_mask  = addr_take && (haddr == vcc_pkg::MASK_ADDR);
        next_r.hrdata   = 32'h0000_0000;
        if (addr_take && !hwrite && haddr == vcc_pkg::CTRL_ADDR) begin
            next_r.hrdata = {21'h00_0000, next_r.ctrl};
        end else if (addr_take && !hwrite && haddr == vcc_pkg::MASK_ADDR) begin
            next_r.hrdata = {30'h0000_0000, next_r.mask};
        end
        next_r.hreadyout = 1'b1;

        // result distribution
        next_r.pla_out    = r.ctrl.compare_on && mon;
        next_r.adc_start  = rise_evt;
        next_r.result_pin = (r.ctrl.output_route == vcc_pkg::ROUTE_PIN)
                            && r.ctrl.compare_on && mon;
        next_r.irq        = (r.ctrl.output_route == vcc_pkg::ROUTE_IRQ)
                            && |({r.ctrl.rise_flag, r.ctrl.fall_flag} & r.mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= RESET_STATE;
        end else begin
            r <= next_r;
        end
    end

    assign hreadyout          = r.hreadyout;
    assign hresp              = 1'b0;
    assign hrdata             = r.hrdata;
    assign compare_on         = r.ctrl.compare_on;
    assign minus_input_select = r.ctrl.minus_input_select;
    assign response_speed     = r.ctrl.response_speed;
    assign hysteresis_on      = r.ctrl.hysteresis_on;
    assign result_pin         = r.result_pin;
    assign pla_out            = r.pla_out;
    assign adc_start          = r.adc_start;
    assign irq                = r.irq;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_RISE_SET: assert property (rise_evt |=> r.ctrl.rise_flag)
        else $error("rising edge did not set rise flag");
    AST_FALL_SET: assert property (fall_evt |=> r.ctrl.fall_flag)
        else $error("falling edge did not set fall flag");
    AST_RISE_HOLD: assert property (r.ctrl.rise_flag && !(wr_ctrl && hwdata[1])
                                    |=> r.ctrl.rise_flag)
        else $error("rise flag lost without a one write");
    AST_FALL_CLEAR: assert property (r.ctrl.fall_flag && wr_ctrl && hwdata[0] && !fall_evt
                                     |=> !r.ctrl.fall_flag)
        else $error("fall flag not cleared by one write");
    AST_ENABLE: assert property (wr_ctrl |=> compare_on == $past(hwdata[10]))
        else $error("enable bit not taken from write");
    AST_PIN_ROUTE: assert property (r.ctrl.output_route != vcc_pkg::ROUTE_PIN
                                    |=> !result_pin)
        else $error("output pin driven while not routed");
    AST_IRQ: assert property (r.ctrl.rise_flag && r.mask[1]
                              && r.ctrl.output_route == vcc_pkg::ROUTE_IRQ |=> irq)
        else $error("interrupt missing for masked-in flag");
    AST_POLARITY: assert property (r.ctrl.compare_on && !r.ctrl.output_polarity
                                   |=> pla_out == $past(raw_level))
        else $error("result polarity wrong");
    AST_RSVD_ZERO: assert property (r.dp_ctrl && !r.dp_write |-> hrdata[31:11] == 21'h0)
        else $error("reserved bits read nonzero");
    AST_ONE_SET: assert property (rise_evt |=> !rise_evt)
        else $error("edge counted twice");

    COV_RISE: cover property (rise_evt ##1 r.ctrl.rise_flag);
    COV_FALL_CLR: cover property (r.ctrl.fall_flag ##1 !r.ctrl.fall_flag);
    COV_IRQ: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// ---- tb/vcc_cmp_model.sv ----
// comparator model: analogue levels as reals, thresholded to a digital result
`timescale 1ns/1ps
`default_nettype none
module vcc_cmp_model (
    input  wire logic       compare_on,
    input  wire logic [1:0] minus_input_select,
    output logic            comparator_raw
);
    real v_plus = 1.0;
    real v_third_analog_input = 0.5;
    real v_first_dac_output = 2.0;
    real v_minus;
    always @* begin
        // half supply, third adc input or first dac output
        v_minus = (minus_input_select == 2'h1) ? v_third_analog_input :
                  (minus_input_select == 2'h2) ? v_first_dac_output : 1.65;
        comparator_raw = compare_on && (v_plus > v_minus);
    end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench: register access, fields, edge flags, routing
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
    logic [1:0]  htrans = 2'h0;
    logic        hreadyout, hresp, raw, con, hyst, rpin, programmable_logic_array, adcs, irq, s_rdy;
    logic [31:0] hrdata, s_rd;
    logic [1:0]  msel, spd;
    int          n_errors = 0, n_tests = 0, n_adc = 0;
    localparam logic [31:0] C = vcc_pkg::CTRL_ADDR;
    localparam logic [31:0] M = vcc_pkg::MASK_ADDR;
    vcc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .comparator_raw(raw), .compare_on(con), .minus_input_select(msel),
        .response_speed(spd), .hysteresis_on(hyst), .result_pin(rpin),
        .pla_out(programmable_logic_array), .adc_start(adcs), .irq(irq));
    vcc_cmp_model model (.compare_on(con), .minus_input_select(msel), .comparator_raw(raw));
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    always @(negedge hclk) begin
        s_rdy <= hreadyout;
        s_rd  <= hrdata;
    end
    // count one-cycle conversion-start pulses
    always @(posedge hclk) begin
        if (adcs === 1'b1) begin
            n_adc++;
        end
    end
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; htrans <= vcc_pkg::HTRANS_NSEQ; hwrite <= w;
        do @(posedge hclk); while (s_rdy !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (s_rdy !== 1'b1);
        r = s_rd;
        // let registered outputs settle before any compare
        @(negedge hclk);
    endtask
    task rd(input logic [31:0] a, input logic [31:0] exp, input string name);
        xfer(1'b0, a, 32'h0);
        chk(name, exp, r);
    endtask
    task settle;
        repeat (12) @(posedge hclk);
    endtask
    task t_reset;
        rd(C, 32'h0, "ctrl reset");
        rd(M, 32'h0, "mask reset");
        rd(32'hffff0440, 32'h0, "unmapped read");
        chk("hresp", 32'h0, {31'h0, hresp});
        $display("test reset done");
    endtask
    task t_fields;
        xfer(1'b1, C, 32'hfffffbfc);
        rd(C, 32'h000003fc, "ctrl reserved");
        chk("compare_on", 32'h0, {31'h0, con});
        chk("minus_sel", 32'h3, {30'h0, msel});
        chk("speed", 32'h3, {30'h0, spd});
        chk("hyst", 32'h1, {31'h0, hyst});
        xfer(1'b1, C, 32'h0);
        chk("hyst off", 32'h0, {31'h0, hyst});
        $display("test fields done");
    endtask
    task t_edges;
        xfer(1'b1, M, 32'h3);
        xfer(1'b1, C, 32'h04c0);
        chk("compare_on", 32'h1, {31'h0, con});
        settle;
        xfer(1'b1, C, 32'h05c0);
        settle;
        rd(C, 32'h05c2, "rise flag");
        chk("irq", 32'h1, {31'h0, irq});
        chk("pla_out", 32'h1, {31'h0, programmable_logic_array});
        chk("adc_start pulses", 32'h1, n_adc);
        xfer(1'b1, C, 32'h05c2);
        rd(C, 32'h05c0, "rise clear");
        chk("irq clear", 32'h0, {31'h0, irq});
        xfer(1'b1, C, 32'h04c0);
        settle;
        rd(C, 32'h04c1, "fall flag");
        xfer(1'b1, C, 32'h04c0);
        rd(C, 32'h04c1, "fall zero write");
        xfer(1'b1, C, 32'h04c1);
        rd(C, 32'h04c0, "fall clear");
        $display("test edges done");
    endtask
    task t_pin;
        xfer(1'b1, C, 32'h04a0);
        settle;
        chk("result_pin", 32'h1, {31'h0, rpin});
        chk("irq off route", 32'h0, {31'h0, irq});
        rd(C, 32'h04a2, "polarity rise");
        $display("test pin done");
    endtask
    task stop_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_fields;
        t_edges;
        t_pin;
        stop_test;
    end
    initial begin
        repeat (3000) @(posedge hclk);
        n_errors++;
        stop_test;
    end
endmodule
`default_nettype wire
